// *** board_strap_config_decoder.sv ***
// Board strap decoder: latches switches and jumpers, drives configuration
//
// Notes on behaviour
// [RULE1] Boot selector code appears in status bits 7 to 4.
// [RULE2] Boot selector has sixteen positions; matters only when firmware runs.
// [RULE3] Special interrupts go to user code for 8-15, firmware for 0-7; the code routes positions 7 and 15 to neither.
// [RULE4] User-handled halt or init leaves the application running.
// [RULE5] PROM maps low for positions 0,1,2,8,9,10, else high.
// [RULE6] 0/8 no tests; 1/9 all tests; 2/10 also user PROM checksum.
// [RULE7] 3/11 run all tests then tape boot over console serial unit.
// [RULE8] 4/12 enter console monitor with no selftests.
// [RULE9] 5,6,13,14 await mailbox word zero; 5/13 test first, 6/14 not.
// [RULE10] 7/15 loop all selftests, no boot; loopback plugs expected.
// [RULE11] Expected checksum is the word at the PROM's highest address.
// [RULE12] Checksum starts at zero: add word, drop carry, rotate left one.
// [RULE13] Backplane addressing is 16, 18 or 22 bits by jumpers.
// [RULE14] ID 0 or 1 disables backplane: standalone processor.
// [RULE15] ID 2-7 base 17760100 or 17762100 octal plus 40 per step.
// [RULE16] ID 8-15 base 17775400 or 17777400 octal plus 40 per step.
// [RULE17] 16 or 18 bit addressing keeps only the low base bits.
// [RULE18] DMA 0 from serial A; DMA 1 from serial B or parallel port A.
// [RULE19] Configurer enables at most two DMA sources at once.
// [RULE20] Break from console serial unit enters monitor only when enabled.
// [RULE21] Monitor strap fitted: no firmware at power-up, selector ignored.
// [RULE22] 16-bit PROM strap: skip user PROM checksum and sizing.
// [RULE23] ID 2 to 15 select I/O processor mode on the backplane.
// [RULE24] All straps are latched after each reset and held until next.
`default_nettype none
module board_strap_config_decoder (
  input  wire logic                      mclk,          // 10 MHz clock
  input  wire logic                      rst_n,         // Sync reset
  input  wire board_strap_pkg::strap_t   straps,        // Switches, jumpers
  input  wire logic                      serial_a_req,  // DMA req, ser A
  input  wire logic                      serial_b_req,  // DMA req, ser B
  input  wire logic                      pio_a_req,     // DMA req, par A
  input  wire logic                      break_rx,      // Console break
  input  wire logic                      halt_line,     // Backplane halt
  input  wire logic                      init_line,     // Backplane init
  input  wire logic                      chk_start,     // Clear checksum
  input  wire logic                      chk_word_valid, // PROM word here
  input  wire logic                      chk_word_last, // Highest address
  input  wire logic [15:0]               chk_word,      // PROM word
  output logic                           config_valid,  // Straps latched
  output logic [7:0]                     board_status,  // Status register
  output board_strap_pkg::board_cfg_t    board_cfg,     // Boot behaviour
  output board_strap_pkg::bus_cfg_t      bus_cfg,       // Backplane setup
  output logic                           dma_ch0_req,   // To DMA engine
  output logic                           dma_ch1_req,   // To DMA engine
  output logic                           break_to_monitor, // Enter monitor
  output logic                           special_to_user,  // Pulse
  output logic                           special_to_firmware, // Pulse
  output logic [15:0]                    chk_sum,       // Running sum
  output logic                           chk_done,      // Pulse
  output logic                           chk_ok         // Sum matched
);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // Strap sampling and latch
  // One sampling stage before the latch, so the latched copy never
  // sees a switch that was still moving during the reset edge.
  board_strap_pkg::strap_t strap_q;
  logic                    armed;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      strap_q <= '0;
      armed   <= 1'b0;
    end else begin
      strap_q <= straps;
      armed   <= 1'b1;
    end
  end

  wire logic capture = armed & ~config_valid; // see [RULE24]

  // ==========================================================
  // Boot selector decode
  wire logic [2:0] sel_pos   = strap_q.boot_sel[2:0]; // see [RULE2]
  wire logic       sel_upper = strap_q.boot_sel[3];
  wire logic       monitor_strap = strap_q.monitor_jmp;

  wire logic pos_user = (sel_pos == board_strap_pkg::POS_USER_PLAIN) |
                        (sel_pos == board_strap_pkg::POS_USER_TEST) |
                        (sel_pos == board_strap_pkg::POS_USER_CHK);
  wire logic pos_mbx  = (sel_pos == board_strap_pkg::POS_MBX_TEST) |
                        (sel_pos == board_strap_pkg::POS_MBX_NOTEST);
  wire logic pos_loop = (sel_pos == board_strap_pkg::POS_TEST_LOOP);

  // Which positions run the full selftest set
  wire logic pos_tests = (sel_pos == board_strap_pkg::POS_USER_TEST) |
                         (sel_pos == board_strap_pkg::POS_USER_CHK) |
                         (sel_pos == board_strap_pkg::POS_TAPE_BOOT) |
                         (sel_pos == board_strap_pkg::POS_MBX_TEST) |
                         pos_loop; // see [RULE6] [RULE7] [RULE9] [RULE10]

  board_strap_pkg::boot_action_t sel_action;

  always_comb begin
    sel_action = board_strap_pkg::ACT_USER_PROM; // see [RULE6]
    if (sel_pos == board_strap_pkg::POS_TAPE_BOOT) begin
      sel_action = board_strap_pkg::ACT_TAPE_BOOT; // see [RULE7]
    end else if (sel_pos == board_strap_pkg::POS_MONITOR) begin
      sel_action = board_strap_pkg::ACT_MONITOR; // see [RULE8]
    end else if (pos_mbx) begin
      sel_action = board_strap_pkg::ACT_AWAIT_MAILBOX; // see [RULE9]
    end else if (pos_loop) begin
      sel_action = board_strap_pkg::ACT_SELFTEST_LOOP; // see [RULE10]
    end
  end

  // Monitor strap overrides the selector for power-up behaviour only
  wire board_strap_pkg::boot_action_t next_action =
    monitor_strap ? board_strap_pkg::ACT_MONITOR : sel_action; // see [RULE21]
  wire logic next_tests = pos_tests & ~monitor_strap; // see [RULE21]
  wire logic next_loop  = pos_loop & ~monitor_strap;
  wire logic next_chk   = next_tests & ~strap_q.prom16_jmp &
    (sel_pos == board_strap_pkg::POS_USER_CHK); // see [RULE6] [RULE22]

  board_strap_pkg::board_cfg_t next_board_cfg;

  always_comb begin
    next_board_cfg                   = '0;
    next_board_cfg.action            = next_action;
    next_board_cfg.all_selftests     = next_tests;
    next_board_cfg.selftest_loop     = next_loop; // see [RULE10]
    next_board_cfg.loopback_expected = next_loop;
    next_board_cfg.user_checksum     = next_chk;
    next_board_cfg.user_sizing       = ~strap_q.prom16_jmp; // see [RULE22]
    next_board_cfg.prom_high         = ~pos_user; // see [RULE5]
    next_board_cfg.user_special      = sel_upper & ~pos_loop; // see [RULE3]
    next_board_cfg.firmware_special  = ~sel_upper & ~pos_loop;
    next_board_cfg.run_firmware      = ~monitor_strap; // see [RULE21]
    next_board_cfg.break_en          = strap_q.break_jmp;
    next_board_cfg.dma_a_en          = strap_q.dma_a_jmp;
    next_board_cfg.dma_b_en          = strap_q.dma_b_jmp;
    next_board_cfg.dma_pio_en        = strap_q.dma_pio_jmp;
    // Both channel-1 sources fitted is unsupported; flagged, OR-ed below
    next_board_cfg.dma_conflict      = strap_q.dma_b_jmp &
                                       strap_q.dma_pio_jmp; // see [RULE19]
  end

  // ==========================================================
  // Backplane address decode
  wire logic [3:0] id_pos   = strap_q.id_sel;
  wire logic       id_iop   = (id_pos >= board_strap_pkg::ID_FIRST_IOP);
  wire logic       id_high  = (id_pos >= board_strap_pkg::ID_FIRST_HIGH);
  wire logic [3:0] id_first = id_high ? board_strap_pkg::ID_FIRST_HIGH :
                                        board_strap_pkg::ID_FIRST_IOP;
  wire logic [3:0] id_step  = id_pos - id_first;

  wire logic [21:0] group_base =
    id_high ? (strap_q.base_jmp ? board_strap_pkg::BASE_HIGH_FITTED :
                                  board_strap_pkg::BASE_HIGH_REMOVED) :
              (strap_q.base_jmp ? board_strap_pkg::BASE_LOW_FITTED :
                                  board_strap_pkg::BASE_LOW_REMOVED);

  wire logic [21:0] step_offset = {board_strap_pkg::BASE_STEP_ZEROS,
                                   id_step, board_strap_pkg::BASE_STEP_PAD};
  wire logic [21:0] full_base = group_base + step_offset; // see [RULE15] [RULE16]

  wire board_strap_pkg::addr_width_t next_width =
    (strap_q.width_jmp == board_strap_pkg::WIDTH_JMP_22) ?
      board_strap_pkg::AW_22 :
    (strap_q.width_jmp == board_strap_pkg::WIDTH_JMP_18) ?
      board_strap_pkg::AW_18 : board_strap_pkg::AW_16; // see [RULE13]

  wire logic [21:0] width_mask =
    (next_width == board_strap_pkg::AW_22) ? board_strap_pkg::ADDR_MASK_22 :
    (next_width == board_strap_pkg::AW_18) ? board_strap_pkg::ADDR_MASK_18 :
                                             board_strap_pkg::ADDR_MASK_16;

  board_strap_pkg::bus_cfg_t next_bus_cfg;

  always_comb begin
    next_bus_cfg                   = '0;
    next_bus_cfg.io_processor_mode = id_iop; // see [RULE14] [RULE23]
    next_bus_cfg.width             = next_width;
    next_bus_cfg.id_pos            = id_pos;
    // Standalone boards decode no base at all
    next_bus_cfg.base = id_iop ? (full_base & width_mask) : '0; // see [RULE17]
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      config_valid <= 1'b0;
      board_status <= 8'h00;
      board_cfg    <= '0;
      bus_cfg      <= '0;
    end else if (capture) begin
      config_valid <= 1'b1;
      board_status <= {strap_q.boot_sel,
                       board_strap_pkg::STATUS_LOW_RSV}; // see [RULE1]
      board_cfg    <= next_board_cfg;
      bus_cfg      <= next_bus_cfg;
    end
  end

  AST_STATUS_CODE: assert property ($rose(config_valid) |->  // see [RULE1]
    board_status[7:4] == $past(strap_q.boot_sel))
    else $error("status code differs from boot selector");

  AST_HELD_STABLE: assert property (config_valid && $past(config_valid) |-> // see [RULE24]
    $stable(board_cfg) && $stable(bus_cfg) && $stable(board_status))
    else $error("latched configuration changed before reset");

  AST_PROM_MAP: assert property (config_valid |->  // see [RULE5]
    board_cfg.prom_high == (board_status[6:4] > 3'h2))
    else $error("PROM mapping does not match selector");

  AST_STANDALONE: assert property (config_valid && bus_cfg.id_pos < 4'h2 |-> // see [RULE14]
    !bus_cfg.io_processor_mode && bus_cfg.base == 22'h00_0000)
    else $error("standalone ID left backplane enabled");

  AST_BASE_MASK: assert property (config_valid &&  // see [RULE17]
    bus_cfg.width == board_strap_pkg::AW_16 |-> bus_cfg.base[21:16] == 6'h00)
    else $error("16-bit addressing kept upper base bits");

  // ==========================================================
  // Live request routing
  logic halt_q;
  logic init_q;

  wire logic special_evt = (halt_line & ~halt_q) | (init_line & ~init_q);
  wire logic special_ok  = config_valid & bus_cfg.io_processor_mode;

  // User handling raises an event and never stops the application
  wire logic next_to_user = special_evt & special_ok &
                            board_cfg.user_special; // see [RULE3] [RULE4]
  wire logic next_to_fw   = special_evt & special_ok &
                            board_cfg.firmware_special; // see [RULE3]
  wire logic next_ch0 = config_valid & board_cfg.dma_a_en &
                        serial_a_req; // see [RULE18]
  wire logic next_ch1 = config_valid &
    ((board_cfg.dma_b_en & serial_b_req) |
     (board_cfg.dma_pio_en & pio_a_req)); // see [RULE18]
  wire logic next_break = config_valid & board_cfg.break_en &
                          break_rx; // see [RULE20]

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      halt_q              <= 1'b0;
      init_q              <= 1'b0;
      special_to_user     <= 1'b0;
      special_to_firmware <= 1'b0;
      dma_ch0_req         <= 1'b0;
      dma_ch1_req         <= 1'b0;
      break_to_monitor    <= 1'b0;
    end else begin
      halt_q              <= halt_line;
      init_q              <= init_line;
      special_to_user     <= next_to_user;
      special_to_firmware <= next_to_fw;
      dma_ch0_req         <= next_ch0;
      dma_ch1_req         <= next_ch1;
      break_to_monitor    <= next_break;
    end
  end

  sequence seq_break_allowed;
    config_valid && board_cfg.break_en && break_rx;
  endsequence

  AST_BREAK_PASS: assert property (seq_break_allowed |=> break_to_monitor) // see [RULE20]
    else $error("enabled break did not reach the monitor");

  AST_BREAK_BLOCK: assert property (config_valid && !board_cfg.break_en |=> // see [RULE20]
    !break_to_monitor)
    else $error("disabled break reached the monitor");

  AST_SPECIAL_USER: assert property (special_to_user |->  // see [RULE3]
    board_status[7] && board_status[6:4] != 3'h7 && !special_to_firmware)
    else $error("special event sent to user for a low position");

  AST_SPECIAL_LOOP: assert property (config_valid &&  // see [RULE3]
    board_status[6:4] == 3'h7 |-> !special_to_user && !special_to_firmware)
    else $error("loop positions handled a special event");

  AST_DMA_CH0: assert property (config_valid && board_cfg.dma_a_en &&  // see [RULE18]
    serial_a_req |=> dma_ch0_req)
    else $error("serial A request lost on DMA channel 0");

  // ==========================================================
  // PROM checksum engine
  // The highest word is compared, not summed; start wins over a word.
  wire logic [15:0] chk_add = chk_sum + chk_word; // see [RULE12]
  wire logic [15:0] chk_rot = {chk_add[14:0], chk_add[15]}; // see [RULE12]
  wire logic chk_accum = chk_word_valid & ~chk_word_last & ~chk_start;
  wire logic chk_final = chk_word_valid & chk_word_last & ~chk_start;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      chk_sum  <= board_strap_pkg::CHECKSUM_SEED;
      chk_done <= 1'b0;
      chk_ok   <= 1'b0;
    end else begin
      chk_done <= chk_final;
      if (chk_start) begin
        chk_sum <= board_strap_pkg::CHECKSUM_SEED; // see [RULE12]
        chk_ok  <= 1'b0;
      end else if (chk_accum) begin
        chk_sum <= chk_rot;
      end else if (chk_final) begin
        chk_ok <= (chk_sum == chk_word); // see [RULE11]
      end
    end
  end

  sequence seq_one_word;
    chk_start ##1 (chk_accum && chk_word == 16'h8001);
  endsequence

  AST_CHK_ROTATE: assert property (seq_one_word |=>  // see [RULE12]
    chk_sum == 16'h0003)
    else $error("checksum add and rotate is wrong");

  AST_CHK_COMPARE: assert property (chk_done |->  // see [RULE11]
    chk_ok == (chk_sum == $past(chk_word)) && $stable(chk_sum))
    else $error("checksum compare against highest word is wrong");

endmodule
`default_nettype wire

// *** board_strap_model.sv ***
// Switch and jumper model that sets the decoder's strap pins
`default_nettype none
module board_strap_model (
  input  wire board_strap_pkg::strap_t want,      // Requested setting
  input  wire logic                    allow_bad, // Permit shorted DMA link
  output var  board_strap_pkg::strap_t straps     // Settings on the pins
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // Jumper fitting
  // A careful configurer never links serial B and the parallel port
  // onto channel 1 together; only a deliberate scenario may do so.
  always_comb begin
    straps = want;
    if (want.dma_b_jmp && !allow_bad) begin
      straps.dma_pio_jmp = 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** board_strap_pkg.sv ***
// Shared constants and carrier types for the board strap decoder
`default_nettype none
package board_strap_pkg;

  // ==========================================================
  // Backplane base addresses (22-bit, fixed by the ID switch and the base jumper)
  localparam logic [21:0] BASE_LOW_FITTED   = 22'h3f_e040;
  localparam logic [21:0] BASE_LOW_REMOVED  = 22'h3f_e440;
  localparam logic [21:0] BASE_HIGH_FITTED  = 22'h3f_fb00;
  localparam logic [21:0] BASE_HIGH_REMOVED = 22'h3f_ff00;
  localparam logic [21:0] ADDR_MASK_16      = 22'h00_ffff;
  localparam logic [21:0] ADDR_MASK_18      = 22'h03_ffff;
  localparam logic [21:0] ADDR_MASK_22      = 22'h3f_ffff;
  localparam logic [4:0]  BASE_STEP_PAD     = 5'h00;
  localparam logic [12:0] BASE_STEP_ZEROS   = 13'h0000;

  // ==========================================================
  // ID switch groups
  localparam logic [3:0] ID_FIRST_IOP  = 4'h2;
  localparam logic [3:0] ID_FIRST_HIGH = 4'h8;

  // ==========================================================
  // Boot selector positions, low three bits (8-15 mirror 0-7)
  localparam logic [2:0] POS_USER_PLAIN = 3'h0;
  localparam logic [2:0] POS_USER_TEST  = 3'h1;
  localparam logic [2:0] POS_USER_CHK   = 3'h2;
  localparam logic [2:0] POS_TAPE_BOOT  = 3'h3;
  localparam logic [2:0] POS_MONITOR    = 3'h4;
  localparam logic [2:0] POS_MBX_TEST   = 3'h5;
  localparam logic [2:0] POS_MBX_NOTEST = 3'h6;
  localparam logic [2:0] POS_TEST_LOOP  = 3'h7;

  // ==========================================================
  // Width jumper codes, status layout, checksum seed
  localparam logic [1:0]  WIDTH_JMP_22   = 2'h3;
  localparam logic [1:0]  WIDTH_JMP_18   = 2'h2;
  localparam logic [3:0]  STATUS_LOW_RSV = 4'h0;
  localparam logic [15:0] CHECKSUM_SEED  = 16'h0000;

  typedef enum logic [2:0] {
    ACT_USER_PROM,
    ACT_TAPE_BOOT,
    ACT_MONITOR,
    ACT_AWAIT_MAILBOX,
    ACT_SELFTEST_LOOP
  } boot_action_t;

  typedef enum logic [1:0] {
    AW_16,
    AW_18,
    AW_22
  } addr_width_t;

  typedef struct packed {
    logic [3:0] boot_sel;
    logic [3:0] id_sel;
    logic [1:0] width_jmp;
    logic       base_jmp;
    logic       dma_a_jmp;
    logic       dma_b_jmp;
    logic       dma_pio_jmp;
    logic       break_jmp;
    logic       monitor_jmp;
    logic       prom16_jmp;
  } strap_t;

  typedef struct packed {
    boot_action_t action;
    logic         all_selftests;
    logic         selftest_loop;
    logic         loopback_expected;
    logic         user_checksum;
    logic         user_sizing;
    logic         prom_high;
    logic         user_special;
    logic         firmware_special;
    logic         run_firmware;
    logic         break_en;
    logic         dma_a_en;
    logic         dma_b_en;
    logic         dma_pio_en;
    logic         dma_conflict;
  } board_cfg_t;

  typedef struct packed {
    logic        io_processor_mode;
    addr_width_t width;
    logic [3:0]  id_pos;
    logic [21:0] base;
  } bus_cfg_t;

endpackage
`default_nettype wire

// *** tb_board_strap_config_decoder.sv ***
// Self-checking bench for the board strap configuration decoder
`default_nettype none
module tb_board_strap_config_decoder;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // Signals
  logic                         mclk = 1'b0;
  logic                         rst_n, allow_bad, live_chk, cv_q;
  logic                         serial_a_req, serial_b_req, pio_a_req;
  logic                         break_rx, halt_line, init_line;
  logic                         chk_start, chk_word_valid, chk_word_last;
  logic [15:0]                  chk_word, chk_sum;
  board_strap_pkg::strap_t      want, straps;
  logic                         config_valid, dma_ch0_req, dma_ch1_req;
  logic [7:0]                   board_status, cnt_u, cnt_f, exp_u, exp_f;
  board_strap_pkg::board_cfg_t  board_cfg;
  board_strap_pkg::bus_cfg_t    bus_cfg;
  logic                         break_to_monitor, chk_done, chk_ok;
  logic                         special_to_user, special_to_firmware;
  logic [31:0]                  seed;
  logic [53:0]                  q_cfg[$];
  logic [16:0]                  q_chk[$];
  logic [72:0]                  q_live[$];
  logic [72:0]                  ev;
  integer                       errors, n_tests, cycles;

  board_strap_model i_board_strap_model (.want(want), .allow_bad(allow_bad),
    .straps(straps));

  board_strap_config_decoder i_board_strap_config_decoder (
    .mclk(mclk), .rst_n(rst_n), .straps(straps),
    .serial_a_req(serial_a_req), .serial_b_req(serial_b_req),
    .pio_a_req(pio_a_req), .break_rx(break_rx), .halt_line(halt_line),
    .init_line(init_line), .chk_start(chk_start),
    .chk_word_valid(chk_word_valid), .chk_word_last(chk_word_last),
    .chk_word(chk_word), .config_valid(config_valid),
    .board_status(board_status), .board_cfg(board_cfg), .bus_cfg(bus_cfg),
    .dma_ch0_req(dma_ch0_req), .dma_ch1_req(dma_ch1_req),
    .break_to_monitor(break_to_monitor), .special_to_user(special_to_user),
    .special_to_firmware(special_to_firmware), .chk_sum(chk_sum),
    .chk_done(chk_done), .chk_ok(chk_ok));

  always #50 mclk = ~mclk;

  // ==========================================================
  // Helpers
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic compare(input logic [79:0] exp, input logic [79:0] got);
    n_tests++;
    if (exp !== got) begin
      errors++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic rnd(output logic [31:0] v);
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    v = seed;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  function automatic logic [53:0] exp_cfg(input board_strap_pkg::strap_t s);
    board_strap_pkg::board_cfg_t b;
    board_strap_pkg::bus_cfg_t   u;
    logic [2:0]                  p;
    logic [21:0]                 base;
    p = s.boot_sel[2:0];
    b = '0;
    u = '0;
    base = 22'h00_0000;
    case (p)
      3'h0, 3'h1, 3'h2: b.action = board_strap_pkg::ACT_USER_PROM;
      3'h3: b.action = board_strap_pkg::ACT_TAPE_BOOT;
      3'h4: b.action = board_strap_pkg::ACT_MONITOR;
      3'h5, 3'h6: b.action = board_strap_pkg::ACT_AWAIT_MAILBOX;
      default: b.action = board_strap_pkg::ACT_SELFTEST_LOOP;
    endcase
    b.all_selftests = p inside {3'h1, 3'h2, 3'h3, 3'h5, 3'h7};
    b.selftest_loop = (p == 3'h7);
    b.loopback_expected = (p == 3'h7);
    b.user_checksum = (p == 3'h2) && !s.prom16_jmp;
    b.user_sizing = !s.prom16_jmp;
    b.prom_high = (p > 3'h2);
    b.user_special = s.boot_sel[3] && (p != 3'h7);
    b.firmware_special = !s.boot_sel[3] && (p != 3'h7);
    b.run_firmware = !s.monitor_jmp;
    b.break_en = s.break_jmp;
    b.dma_a_en = s.dma_a_jmp;
    b.dma_b_en = s.dma_b_jmp;
    b.dma_pio_en = s.dma_pio_jmp;
    b.dma_conflict = s.dma_b_jmp && s.dma_pio_jmp;
    if (s.monitor_jmp) begin
      b.action = board_strap_pkg::ACT_MONITOR;
      b.all_selftests = 1'b0;
      b.selftest_loop = 1'b0;
      b.loopback_expected = 1'b0;
      b.user_checksum = 1'b0;
    end
    u.io_processor_mode = (s.id_sel >= 4'h2);
    u.id_pos = s.id_sel;
    u.width = (s.width_jmp == 2'h3) ? board_strap_pkg::AW_22 :
              (s.width_jmp == 2'h2) ? board_strap_pkg::AW_18 :
              board_strap_pkg::AW_16;
    if (s.id_sel >= 4'h8) begin
      base = (s.base_jmp ? board_strap_pkg::BASE_HIGH_FITTED :
              board_strap_pkg::BASE_HIGH_REMOVED) + {s.id_sel - 4'h8, 5'h00};
    end else if (s.id_sel >= 4'h2) begin
      base = (s.base_jmp ? board_strap_pkg::BASE_LOW_FITTED :
              board_strap_pkg::BASE_LOW_REMOVED) + {s.id_sel - 4'h2, 5'h00};
    end
    if (u.width == board_strap_pkg::AW_16) base = base & 22'h00_ffff;
    if (u.width == board_strap_pkg::AW_18) base = base & 22'h03_ffff;
    u.base = base;
    return {s.boot_sel, 4'h0, b, u};
  endfunction

  // ==========================================================
  // Result watcher: each result takes the oldest note of its kind
  always @(negedge mclk) begin
    if (special_to_user === 1'b1) cnt_u <= cnt_u + 8'h01;
    if (special_to_firmware === 1'b1) cnt_f <= cnt_f + 8'h01;
    cv_q <= config_valid;
    if (config_valid === 1'b1 && cv_q !== 1'b1 && q_cfg.size() > 0) begin
      ev = {19'h0_0000, q_cfg.pop_front()};
      compare(ev[53:46], board_status);
      compare(ev[45:37], board_cfg[16:8]);
      compare(ev[36:29], board_cfg[7:0]);
      compare(ev[28:0], bus_cfg);
    end
    if (chk_done === 1'b1 && q_chk.size() > 0) begin
      compare(q_chk.pop_front(), {chk_ok, chk_sum});
    end
    if (live_chk === 1'b1 && q_live.size() > 0) begin
      ev = q_live.pop_front();
      compare(ev[72:19], {board_status, board_cfg, bus_cfg});
      compare(ev[18:16], {dma_ch0_req, dma_ch1_req, break_to_monitor});
      compare(ev[15:0], {cnt_u, cnt_f});
    end
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      complete_run();
    end
  end

  // ==========================================================
  // One strap setting: latch, live routing, checksum
  task automatic run_cfg(input int i);
    logic [31:0]                 r;
    logic [53:0]                 e;
    logic [15:0]                 sum, s2;
    board_strap_pkg::strap_t     w;
    board_strap_pkg::board_cfg_t bc;
    board_strap_pkg::bus_cfg_t   uc;
    logic [7:0]                  st;
    rnd(r);
    w = board_strap_pkg::strap_t'(r[16:0]);
    w.boot_sel = i[3:0];
    w.id_sel = i[3:0] ^ 4'h5;
    w.monitor_jmp = r[20] & r[21];
    allow_bad = (i == 13);
    want = w;
    rst_n = 1'b0;
    tick(2);
    e = exp_cfg(straps);
    {st, bc, uc} = e;
    q_cfg.push_back(e);
    rst_n = 1'b1;
    tick(1);
    rnd(r);
    want = board_strap_pkg::strap_t'(r[16:0]);
    tick(2);
    repeat (3) begin
      rnd(r);
      {init_line, halt_line, break_rx, pio_a_req, serial_b_req} = r[5:1];
      serial_a_req = r[0];
      tick(1);
      halt_line = 1'b0;
      init_line = 1'b0;
      tick(2);
      if ((r[4] | r[5]) && uc.io_processor_mode && bc.user_special)
        exp_u = exp_u + 8'h01;
      if ((r[4] | r[5]) && uc.io_processor_mode && bc.firmware_special)
        exp_f = exp_f + 8'h01;
      q_live.push_back({e, serial_a_req & bc.dma_a_en,
        (serial_b_req & bc.dma_b_en) | (pio_a_req & bc.dma_pio_en),
        break_rx & bc.break_en, exp_u, exp_f});
      live_chk <= 1'b1;
      tick(1);
      live_chk <= 1'b0;
    end
    rnd(r);
    chk_start = 1'b1;
    tick(1);
    chk_start = 1'b0;
    sum = 16'h0000;
    chk_word_valid = 1'b1;
    repeat (r[1:0] + 1) begin
      rnd(r);
      chk_word = r[15:0];
      s2 = sum + r[15:0];
      sum = {s2[14:0], s2[15]};
      tick(1);
    end
    chk_word = r[8] ? sum : (sum ^ 16'h0001);
    chk_word_last = 1'b1;
    q_chk.push_back({r[8], sum});
    tick(1);
    chk_word_valid = 1'b0;
    chk_word_last = 1'b0;
  endtask

  initial begin
    {serial_a_req, serial_b_req, pio_a_req, break_rx} = 4'h0;
    {halt_line, init_line, chk_start, chk_word_valid} = 4'h0;
    chk_word_last = 1'b0;
    chk_word = 16'h0000;
    want = '0;
    allow_bad = 1'b0;
    live_chk = 1'b0;
    cv_q = 1'b0;
    {cnt_u, cnt_f, exp_u, exp_f} = 32'h0000_0000;
    seed = 32'h0000_dae0;
    errors = 0;
    n_tests = 0;
    cycles = 0;
    rst_n = 1'b0;
    tick(2);
    for (int i = 0; i < 16; i++) run_cfg(i);
    tick(2);
    if (q_cfg.size() + q_chk.size() + q_live.size() != 0) errors++;
    complete_run();
  end
endmodule
`default_nettype wire
